/* pemc_top.v */
// Protocol error mask control: AXI4-Lite register bank plus masking filter.
// Assumes a single 25 MHz clock, synchronous active-high reset, and that
// the error detector presents one error per cycle as a pulse.
`timescale 1ns/1ps
`include "pemc_map.vh"

module pemc_top (
	// Clock and reset
	input  wire        clk,
	input  wire        sys_rst,
	// AXI4-Lite write address
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Error detector
	input  wire        errValid,
	input  wire [5:0]  errSeverity,
	input  wire [2:0]  errClass,
	// Decisions toward log and message logic
	output reg         logStrobe,
	output reg         reportStrobe,
	output reg         errorPending
);
	reg  [1:0] disableField;
	reg  [5:0] severityLogSuppress;
	reg  [5:0] severityReportSuppress;
	reg  [9:0] errorClassMask;
	reg        deviceErrorEnable;
	reg  [7:0] wrAddr;
	reg  [31:0] wrData;
	reg  [3:0] wrStrb;
	reg        haveAddr;
	reg        haveData;
	wire       allowLog;
	wire       allowReport;
	wire       doWrite;
	wire       clearPending;
	wire       setPending;

	// Masks are plain flops feeding a combinational filter, so a write is
	// effective on the very next cycle, ahead of any later read response.
	pemc_filter uFilter (
		.errSeverity            (errSeverity),
		.errClass               (errClass),
		.deviceErrorEnable      (deviceErrorEnable),
		.disableField           (disableField),
		.severityLogSuppress    (severityLogSuppress),
		.severityReportSuppress (severityReportSuppress),
		.errorClassMask         (errorClassMask),
		.allowLog               (allowLog),
		.allowReport            (allowReport)
	);

	assign doWrite = haveAddr && haveData && !s_axi_bvalid;
	assign clearPending = doWrite && (wrAddr == `PEMC_OFF_CTRL_STATUS) && wrStrb[0]
		&& wrData[`PEMC_PEND_BIT];
	assign setPending = errValid && allowLog;

	// Write channels, taken in either order
	always @(posedge clk) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			haveAddr      <= 1'b0;
			haveData      <= 1'b0;
			wrAddr        <= 8'h00;
			wrData        <= 32'h00000000;
			wrStrb        <= 4'h0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PEMC_RESP_OKAY;
		end else begin
			s_axi_awready <= !haveAddr && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !haveData && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				haveAddr <= 1'b1;
				wrAddr   <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				haveData <= 1'b1;
				wrData   <= s_axi_wdata;
				wrStrb   <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				haveAddr     <= 1'b0;
				haveData     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (wrAddr)
					`PEMC_OFF_CTRL_STATUS: s_axi_bresp <= `PEMC_RESP_OKAY;
					`PEMC_OFF_MASK_CTRL:   s_axi_bresp <= `PEMC_RESP_OKAY;
					`PEMC_OFF_DEVICE_CTRL: s_axi_bresp <= `PEMC_RESP_OKAY;
					default:               s_axi_bresp <= `PEMC_RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register file
	always @(posedge clk) begin
		if (sys_rst) begin
			disableField           <= `PEMC_DISABLE_RESET;
			severityLogSuppress    <= `PEMC_SEV_RESET;
			severityReportSuppress <= `PEMC_SEV_RESET;
			errorClassMask         <= `PEMC_CLASS_RESET;
			deviceErrorEnable      <= 1'b0;
		end else if (doWrite) begin
			case (wrAddr)
				`PEMC_OFF_CTRL_STATUS: begin
					if (wrStrb[0])
						disableField <= wrData[`PEMC_LOG_DISABLE_BIT:`PEMC_MSGDIS_BIT];
				end
				`PEMC_OFF_MASK_CTRL: begin
					if (wrStrb[0])
						severityLogSuppress <= wrData[`PEMC_SEV_LOG_MSB:`PEMC_SEV_LOG_LSB];
					if (wrStrb[1])
						severityReportSuppress <= wrData[`PEMC_SEV_REP_MSB:`PEMC_SEV_REP_LSB];
					if (wrStrb[2])
						errorClassMask[7:0] <= wrData[23:16];
					if (wrStrb[3])
						errorClassMask[9:8] <= wrData[`PEMC_CLASS_MSB:24];
				end
				`PEMC_OFF_DEVICE_CTRL: begin
					if (wrStrb[0])
						deviceErrorEnable <= wrData[0];
				end
				default: begin
				end
			endcase
		end
	end

	// Pending flag: set wins over clear; masks never clear it
	always @(posedge clk) begin
		if (sys_rst) begin
			errorPending <= 1'b0;
			logStrobe    <= 1'b0;
			reportStrobe <= 1'b0;
		end else begin
			logStrobe    <= setPending;
			reportStrobe <= errValid && allowReport;
			if (setPending)
				errorPending <= 1'b1;
			else if (clearPending)
				errorPending <= 1'b0;
		end
	end

	// Read channel, one cycle after address taken
	always @(posedge clk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `PEMC_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `PEMC_RESP_OKAY;
				case (s_axi_araddr)
					`PEMC_OFF_CTRL_STATUS:
						s_axi_rdata <= {28'h0000000, disableField, 1'b0, errorPending};
					`PEMC_OFF_MASK_CTRL:
						s_axi_rdata <= {6'h00, errorClassMask, 2'b00, severityReportSuppress,
							2'b00, severityLogSuppress};
					`PEMC_OFF_DEVICE_CTRL:
						s_axi_rdata <= {31'h00000000, deviceErrorEnable};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `PEMC_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

/* pemc_map.vh */
// Register map and constants for the protocol error mask control block.
// Assumes inclusion by bare name from design files in the same folder.
`ifndef PEMC_MAP_VH
`define PEMC_MAP_VH

`define PEMC_ADDR_W          8
`define PEMC_OFF_CTRL_STATUS 8'h00
`define PEMC_OFF_MASK_CTRL   8'h04
`define PEMC_OFF_DEVICE_CTRL 8'h08

`define PEMC_SEV_LOG_LSB     0
`define PEMC_SEV_LOG_MSB     5
`define PEMC_SEV_REP_LSB     8
`define PEMC_SEV_REP_MSB     13
`define PEMC_CLASS_LSB       16
`define PEMC_CLASS_MSB       25

`define PEMC_PEND_BIT        0
`define PEMC_MSGDIS_BIT      2
`define PEMC_LOG_DISABLE_BIT      3

`define PEMC_DISABLE_RESET   2'b11
`define PEMC_SEV_RESET       6'h00
`define PEMC_CLASS_RESET     10'h000

`define PEMC_RESP_OKAY       2'b00
`define PEMC_RESP_SLVERR     2'b10

`endif

/* pemc_filter.v */
// Error filter: decides whether a detected error is logged and reported.
// Assumes a one-hot severity and a class index from the error detector.
`timescale 1ns/1ps
`include "pemc_map.vh"

module pemc_filter (
	// Error description
	input  wire [5:0] errSeverity,
	input  wire [2:0] errClass,
	// Controls
	input  wire       deviceErrorEnable,
	input  wire [1:0] disableField,
	input  wire [5:0] severityLogSuppress,
	input  wire [5:0] severityReportSuppress,
	input  wire [9:0] errorClassMask,
	// Decisions
	output wire       allowLog,
	output wire       allowReport
);
	wire [4:0] classReportMask;
	wire [4:0] classLogMask;
	wire       classInRange;
	wire       validCode;

	genvar i;
	generate
		for (i = 0; i < 5; i = i + 1) begin : gSplit
			assign classReportMask[i] = errorClassMask[2 * i];
			assign classLogMask[i]    = errorClassMask[2 * i + 1];
		end
	endgenerate

	assign classInRange = (errClass < 3'h5);
	// Invalid code 01b is treated as fully disabled
	assign validCode = (disableField != 2'b01);

	assign allowLog = deviceErrorEnable && validCode && !disableField[0] && classInRange
		&& ((errSeverity & severityLogSuppress) == 6'h00)
		&& !classLogMask[errClass];
	assign allowReport = allowLog && !disableField[1]
		&& ((errSeverity & severityReportSuppress) == 6'h00)
		&& !classReportMask[errClass];
endmodule

/* pemc_chk.sv */
// Checker for pemc_top: bus answers held, error decisions timed.
// Assumes it is bound onto the ports of pemc_top.
`timescale 1ns/1ps
module pemc_chk (
	// Clock and reset
	input wire        clk,
	input wire        sys_rst,
	// Register bus
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	// Error path
	input wire        errValid,
	input wire [2:0]  errClass,
	input wire        logStrobe,
	input wire        reportStrobe,
	input wire        errorPending
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bHold: assert property (p_bHold) else $error("bvalid dropped");
	property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rHold: assert property (p_rHold) else $error("read data not held");
	property p_rAns; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rAns: assert property (p_rAns) else $error("read answer late");
	property p_noErr; !errValid |=> !logStrobe && !reportStrobe; endproperty
	a_noErr: assert property (p_noErr) else $error("strobe without error");
	property p_repLog; reportStrobe |-> logStrobe; endproperty
	a_repLog: assert property (p_repLog) else $error("report without log");
	property p_pendSet; logStrobe |-> errorPending; endproperty
	a_pendSet: assert property (p_pendSet) else $error("log without pending");
	property p_pendKeep; errorPending ##1 !$rose(s_axi_bvalid) |-> errorPending; endproperty
	a_pendKeep: assert property (p_pendKeep) else $error("pending lost");
	property p_badClass; errValid && errClass > 3'h4 |=> !logStrobe; endproperty
	a_badClass: assert property (p_badClass) else $error("unknown class logged");
	cover property (errValid ##1 logStrobe);
	cover property (errValid ##1 !logStrobe);
	cover property (reportStrobe);
endmodule
bind pemc_top pemc_chk u_chk (.clk(clk), .sys_rst(sys_rst), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.errValid(errValid), .errClass(errClass), .logStrobe(logStrobe),
	.reportStrobe(reportStrobe), .errorPending(errorPending));

/* test_protocol_error_mask_control.sv */
// Bench for pemc_top: register access, masking, pending flag.
// Assumes pemc_chk is bound to the design.
`timescale 1ns/1ps
`include "pemc_map.vh"
module test_protocol_error_mask_control;
	reg         clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, br = 1'h0;
	reg         arv = 1'h0, rr = 1'h0, ev = 1'h0;
	reg  [7:0]  aa = 8'h0, ra = 8'h0;
	reg  [31:0] wd = 32'h0;
	reg  [5:0]  sv = 6'h1;
	reg  [2:0]  cl = 3'h0;
	wire        awr, wr, bv, arr, rv, lg, rp, pd;
	wire [1:0]  bq, rq;
	wire [31:0] rd;
	integer     n_fail = 0, n_tests = 0, i;
	localparam [7:0] CS = `PEMC_OFF_CTRL_STATUS, MK = `PEMC_OFF_MASK_CTRL;
	localparam [7:0] DV = `PEMC_OFF_DEVICE_CTRL;
	localparam [1:0] OK = `PEMC_RESP_OKAY, SE = `PEMC_RESP_SLVERR;
	pemc_top dut (.clk(clk), .sys_rst(rst), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(bq), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rq), .s_axi_rvalid(rv), .s_axi_rready(rr), .errValid(ev),
		.errSeverity(sv), .errClass(cl), .logStrobe(lg), .reportStrobe(rp),
		.errorPending(pd));
	initial forever #20 clk = ~clk;
	task ck(input string n, input [31:0] e, g);
		n_tests = n_tests + 1;
		if (e !== g) begin
			n_fail = n_fail + 1;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// Both channels offered together, each dropped once taken
	task wa(input [7:0] a, input [31:0] d, input [1:0] e);
		@(posedge clk);
		aa <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		br <= 1'h1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'h0;
			if (wr) wv <= 1'h0;
		end while (!bv);
		br <= 1'h0;
		ck("bresp", e, bq);
	endtask
	task rdr(input [7:0] a, input [31:0] e, input [1:0] q);
		@(posedge clk);
		ra <= a;
		arv <= 1'h1;
		rr <= 1'h1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'h0;
		end while (!rv);
		rr <= 1'h0;
		ck("rdata", e, rd);
		ck("rresp", q, rq);
	endtask
	// Decisions land one edge after the pulse
	task er(input [2:0] c, input [5:0] s, input l, r);
		@(posedge clk);
		ev <= 1'h1;
		cl <= c;
		sv <= s;
		@(posedge clk);
		ev <= 1'h0;
		#1;
		ck("log", l, lg);
		ck("report", r, rp);
	endtask
	task t_reset;
		rdr(CS, 32'hc, OK);
		rdr(MK, 32'h0, OK);
		wa(8'h0c, 32'hffffffff, SE);
		rdr(8'h0c, 32'h0, SE);
		wa(MK, 32'hffffffff, OK);
		rdr(MK, 32'h03ff3f3f, OK);
		$display("reset test done");
	endtask
	task t_class;
		wa(CS, 32'h0, OK);
		wa(DV, 32'h1, OK);
		for (i = 0; i < 10; i = i + 1) begin
			wa(MK, 32'h0, OK);
			er(i / 2, 6'h01, 1'h1, 1'h1);
			wa(MK, 32'h1 << (16 + i), OK);
			er(i / 2, 6'h01, i % 2 == 0, 1'h0);
		end
		er(3'h5, 6'h01, 1'h0, 1'h0);
		$display("class test done");
	endtask
	task t_sev;
		for (i = 0; i < 6; i = i + 1) begin
			wa(MK, 32'h1 << i, OK);
			er(3'h1, 6'h1 << i, 1'h0, 1'h0);
			wa(MK, 32'h100 << i, OK);
			er(3'h1, 6'h1 << i, 1'h1, 1'h0);
		end
		wa(MK, 32'h101, OK);
		er(3'h0, 6'h01, 1'h0, 1'h0);
		er(3'h0, 6'h02, 1'h1, 1'h1);
		$display("severity test done");
	endtask
	task t_codes;
		wa(MK, 32'h0, OK);
		for (i = 0; i < 4; i = i + 1) begin
			wa(CS, i * 4, OK);
			er(3'h2, 6'h04, i % 2 == 0, i == 0);
		end
		$display("codes test done");
	endtask
	task t_pend;
		wa(CS, 32'h1, OK);
		er(3'h3, 6'h01, 1'h1, 1'h1);
		wa(MK, 32'h00c00000, OK);
		rdr(CS, 32'h1, OK);
		er(3'h3, 6'h01, 1'h0, 1'h0);
		wa(CS, 32'h1, OK);
		rdr(CS, 32'h0, OK);
		ck("pending", 1'h0, pd);
		$display("pending test done");
	endtask
	task t_pre;
		wa(DV, 32'h0, OK);
		wa(CS, 32'hc, OK);
		wa(MK, 32'h00030000, OK);
		wa(CS, 32'h0, OK);
		wa(DV, 32'h1, OK);
		er(3'h0, 6'h01, 1'h0, 1'h0);
		ck("pending", 1'h0, pd);
		er(3'h1, 6'h01, 1'h1, 1'h1);
		ck("pending", 1'h1, pd);
		$display("enable order test done");
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		t_reset;
		t_class;
		t_sev;
		t_codes;
		t_pend;
		t_pre;
		give_verdict;
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		n_fail = n_fail + 1;
		give_verdict;
	end
endmodule
